// >>> src/slpseq_top.sv
`timescale 1ns/1ns
module slpseq_top #(
    parameter int RESET_CYC = slpseq_pkg::RESET_PULSE_CYC,
    parameter int SAVE_CYCLES = slpseq_pkg::SAVE_CYC,
    parameter logic HIB_SUPPORTED = 1'b1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic power_button,
    input wire logic wake_event,
    output slpseq_pkg::slpseq_power_t power_ctl,
    output slpseq_pkg::slpseq_boot_t boot_cause,
    output logic irq
);
    import slpseq_pkg::*;

    // Parameter check
    if (RESET_CYC < 1 || RESET_CYC > 255 || SAVE_CYCLES < 1 || SAVE_CYCLES > 255) begin : g_chk
        $error("slpseq_top: timing counts must be 1..255");
    end

    // ********************************************************************
    // Reset release and timer
    // ********************************************************************
    logic rst_n; // Synchronised reset
    logic tmr_load; // Start timer
    logic [7:0] tmr_count; // Timer load value
    logic tmr_done; // Timer expired

    slpseq_reset_sync u_rst (
        .clk(clk),
        .rstn(rstn),
        .rst_sync_n(rst_n)
    );

    slpseq_timer #(.WIDTH(8)) u_tmr (
        .clk(clk),
        .rst_n(rst_n),
        .load(tmr_load),
        .count(tmr_count),
        .done(tmr_done)
    );

    // ********************************************************************
    // APB decode helpers
    // ********************************************************************
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    logic wr_en; // Write in access phase
    assign wr_en = psel && penable && pwrite;

    // ********************************************************************
    // Register state
    // ********************************************************************
    logic [2:0] kind_first_q, kind_first_d; // Sleep kind, first control
    logic [2:0] kind_second_q, kind_second_d; // Sleep kind, second control
    logic trig_first_q, trig_first_d; // First trigger armed
    logic trig_second_q, trig_second_d; // Second trigger armed
    logic wake_first_q, wake_first_d; // Wake status, first half
    logic wake_second_q, wake_second_d; // Wake status, second half
    logic [7:0] hib_code_q, hib_code_d; // Hibernate request code
    logic hib_flag_q, hib_flag_d; // Hibernate supported flag
    logic [IRQ_W-1:0] irq_sts_q, irq_sts_d; // Sticky events
    logic [IRQ_W-1:0] irq_mask_q, irq_mask_d; // Event mask
    logic [31:0] prdata_d;
    logic pslverr_d;
    logic pready_d;
    logic irq_d;

    // ********************************************************************
    // Sequencer state
    // ********************************************************************
    slpseq_state_t st_q, st_d; // Sequencer state
    logic [2:0] target_q, target_d; // Kind being entered
    slpseq_power_t pwr_q, pwr_d; // Power controls
    slpseq_boot_t boot_q, boot_d; // Boot cause
    logic start_seq; // Request to enter sleep
    logic [2:0] start_kind; // Kind requested
    logic [IRQ_W-1:0] ev; // Events this cycle
    logic woke; // Return to working state

    // Power controls in working state
    localparam slpseq_power_t PWR_ON = '{clocks_run: 1'b1, cpu_power: 1'b1, main_power: 1'b1,
        memory_self_refresh: 1'b0, memory_isolate: 1'b0, context_save: 1'b0,
        platform_reset_n: 1'b1, cpu_reset_n: 1'b1};

    // Register next values
    always_comb begin
        kind_first_d = kind_first_q;
        kind_second_d = kind_second_q;
        trig_first_d = trig_first_q;
        trig_second_d = trig_second_q;
        wake_first_d = wake_first_q;
        wake_second_d = wake_second_q;
        hib_code_d = hib_code_q;
        hib_flag_d = hib_flag_q;
        irq_mask_d = irq_mask_q;
        start_seq = 1'b0;
        start_kind = kind_first_q;
        pslverr_d = 1'b0;
        pready_d = psel && !penable;
        if (wr_en) begin
            if (hit(paddr, ADDR_POWER_CONTROL_FIRST)) begin
                // Kind always updates; trigger takes the written bit, so writing zero disarms
                kind_first_d = pwdata[SLEEP_KIND_LSB +: SLEEP_KIND_W];
                trig_first_d = pwdata[SLEEP_TRIGGER_BIT];
            end else if (hit(paddr, ADDR_POWER_CONTROL_SECOND)) begin
                kind_second_d = pwdata[SLEEP_KIND_LSB +: SLEEP_KIND_W];
                trig_second_d = pwdata[SLEEP_TRIGGER_BIT];
            end else if (hit(paddr, ADDR_POWER_STATUS_FIRST)) begin
                if (pwdata[WAKE_STATUS_BIT]) wake_first_d = 1'b0;
            end else if (hit(paddr, ADDR_POWER_STATUS_SECOND)) begin
                if (pwdata[WAKE_STATUS_BIT]) wake_second_d = 1'b0;
            end else if (hit(paddr, ADDR_FIRMWARE_COMMAND_PORT)) begin
                // Hibernate code starts firmware-driven hibernation
                if (pwdata[7:0] == hib_code_q && hib_flag_q && st_q == ST_RUN) begin
                    start_seq = 1'b1;
                    start_kind = KIND_S4;
                end
            end else if (hit(paddr, ADDR_FIRMWARE_CONFIG)) begin
                hib_code_d = pwdata[7:0];
                hib_flag_d = pwdata[HIB_SUPPORTED_BIT] & HIB_SUPPORTED;
            end else if (hit(paddr, ADDR_IRQ_MASK)) begin
                irq_mask_d = pwdata[IRQ_W-1:0];
            end
        end
        // Both halves armed: take the first half's kind
        if (trig_first_q && trig_second_q) begin
            trig_first_d = 1'b0;
            trig_second_d = 1'b0;
            if (st_q == ST_RUN && kind_first_q != KIND_S0) begin
                start_seq = 1'b1;
                start_kind = kind_first_q;
            end
        end
        // Hardware set wins over software clear
        if (woke) begin
            wake_first_d = 1'b1;
            wake_second_d = 1'b1;
        end
        // Error decided at setup so that it stands together with ready
        if (psel && !penable) begin
            pslverr_d = !(hit(paddr, ADDR_POWER_CONTROL_FIRST) || hit(paddr, ADDR_POWER_CONTROL_SECOND) ||
                hit(paddr, ADDR_POWER_STATUS_FIRST) || hit(paddr, ADDR_POWER_STATUS_SECOND) ||
                hit(paddr, ADDR_FIRMWARE_COMMAND_PORT) || hit(paddr, ADDR_FIRMWARE_CONFIG) ||
                hit(paddr, ADDR_IRQ_STATUS) || hit(paddr, ADDR_IRQ_MASK) || hit(paddr, ADDR_SEQ_STATE));
        end
    end

    // Read data mux, registered at setup
    always_comb begin
        prdata_d = 32'h0000_0000;
        if (hit(paddr, ADDR_POWER_CONTROL_FIRST)) begin
            prdata_d[SLEEP_KIND_LSB +: SLEEP_KIND_W] = kind_first_q;
        end else if (hit(paddr, ADDR_POWER_CONTROL_SECOND)) begin
            prdata_d[SLEEP_KIND_LSB +: SLEEP_KIND_W] = kind_second_q;
        end else if (hit(paddr, ADDR_POWER_STATUS_FIRST)) begin
            prdata_d[WAKE_STATUS_BIT] = wake_first_q;
        end else if (hit(paddr, ADDR_POWER_STATUS_SECOND)) begin
            prdata_d[WAKE_STATUS_BIT] = wake_second_q;
        end else if (hit(paddr, ADDR_FIRMWARE_CONFIG)) begin
            prdata_d[7:0] = hib_code_q;
            prdata_d[HIB_SUPPORTED_BIT] = hib_flag_q;
        end else if (hit(paddr, ADDR_IRQ_STATUS)) begin
            prdata_d[IRQ_W-1:0] = irq_sts_q;
        end else if (hit(paddr, ADDR_IRQ_MASK)) begin
            prdata_d[IRQ_W-1:0] = irq_mask_q;
        end else if (hit(paddr, ADDR_SEQ_STATE)) begin
            prdata_d[6:0] = st_q;
            prdata_d[10:8] = target_q;
            prdata_d[12] = boot_q.cold_boot;
            prdata_d[13] = boot_q.resume_vector;
        end
    end

    // Interrupt status: set wins over write-one-to-clear
    always_comb begin
        irq_sts_d = irq_sts_q;
        if (wr_en && hit(paddr, ADDR_IRQ_STATUS)) begin
            irq_sts_d = irq_sts_q & ~pwdata[IRQ_W-1:0];
        end
        irq_sts_d = irq_sts_d | ev;
        irq_d = |(irq_sts_d & irq_mask_d);
    end

    // ********************************************************************
    // Power sequencer
    // ********************************************************************
    always_comb begin
        st_d = st_q;
        target_d = target_q;
        pwr_d = pwr_q;
        boot_d = boot_q;
        tmr_load = 1'b0;
        tmr_count = 8'(SAVE_CYCLES);
        ev = '0;
        woke = 1'b0;
        case (st_q)
            ST_RUN: begin
                pwr_d = PWR_ON;
                if (start_seq) begin
                    target_d = start_kind;
                    st_d = ST_ENTER;
                    ev[IRQ_HIBERNATE_REQ] = (start_kind == KIND_S4) && !(trig_first_q && trig_second_q);
                end
            end
            ST_ENTER: begin
                // S4 and S5 share one path: timed save state then full power off; context_save raised for S4 only
                if (target_q == KIND_S4 || target_q == KIND_S5) begin
                    pwr_d.context_save = (target_q == KIND_S4);
                    tmr_load = 1'b1;
                    st_d = ST_SAVE;
                end else begin
                    pwr_d.memory_self_refresh = 1'b1; // All light states keep memory refreshed
                    pwr_d.clocks_run = 1'b0;
                    pwr_d.cpu_power = (target_q == KIND_S1);
                    pwr_d.memory_isolate = (target_q == KIND_S3);
                    pwr_d.main_power = (target_q != KIND_S3);
                    ev[IRQ_SLEEP_ENTERED] = 1'b1;
                    st_d = ST_CLK_STOP;
                end
            end
            ST_SAVE: begin
                if (tmr_done) begin
                    pwr_d.context_save = 1'b0;
                    pwr_d.clocks_run = 1'b0;
                    pwr_d.cpu_power = 1'b0;
                    pwr_d.main_power = 1'b0;
                    pwr_d.memory_self_refresh = 1'b0;
                    ev[IRQ_SLEEP_ENTERED] = 1'b1;
                    st_d = ST_POWER_OFF;
                end
            end
            ST_CLK_STOP: begin
                // Light states: any wake event or power button press resumes, with no mask applied
                if (wake_event || power_button) begin
                    if (target_q == KIND_S1) begin
                        st_d = ST_RESTART_CLK;
                    end else begin
                        pwr_d.main_power = 1'b1;
                        pwr_d.cpu_power = 1'b1;
                        pwr_d.clocks_run = 1'b1;
                        pwr_d.cpu_reset_n = 1'b0;
                        pwr_d.platform_reset_n = (target_q == KIND_S2);
                        boot_d = '{cold_boot: 1'b0, resume_vector: 1'b1};
                        tmr_load = 1'b1;
                        tmr_count = 8'(RESET_CYC);
                        st_d = ST_WAKE_RESET;
                    end
                    ev[IRQ_WAKE] = 1'b1;
                    ev[IRQ_POWER_BUTTON] = power_button;
                end
            end
            ST_POWER_OFF: begin
                // Deep states: power button restores, soft off cold boots
                if (power_button || (wake_event && target_q == KIND_S4)) begin
                    pwr_d = PWR_ON;
                    pwr_d.cpu_reset_n = 1'b0;
                    pwr_d.platform_reset_n = 1'b0;
                    boot_d.cold_boot = (target_q == KIND_S5);
                    boot_d.resume_vector = (target_q == KIND_S4);
                    tmr_load = 1'b1;
                    tmr_count = 8'(RESET_CYC);
                    ev[IRQ_WAKE] = 1'b1;
                    ev[IRQ_POWER_BUTTON] = power_button;
                    st_d = ST_WAKE_RESET;
                end
            end
            ST_WAKE_RESET: begin
                if (tmr_done) begin
                    st_d = ST_RESTART_CLK;
                end
            end
            ST_RESTART_CLK: begin
                pwr_d = PWR_ON;
                woke = 1'b1;
                st_d = ST_RUN;
            end
            default: begin
                st_d = ST_RUN;
            end
        endcase
    end

    // Registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            kind_first_q <= KIND_S0;
            kind_second_q <= KIND_S0;
            trig_first_q <= 1'b0;
            trig_second_q <= 1'b0;
            wake_first_q <= 1'b0;
            wake_second_q <= 1'b0;
            hib_code_q <= HIB_CODE_RESET;
            hib_flag_q <= 1'b0;
            irq_sts_q <= '0;
            irq_mask_q <= '0;
            st_q <= ST_RUN;
            target_q <= KIND_S0;
            pwr_q <= PWR_ON;
            boot_q <= '{cold_boot: 1'b1, resume_vector: 1'b0};
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
        end else begin
            kind_first_q <= kind_first_d;
            kind_second_q <= kind_second_d;
            trig_first_q <= trig_first_d;
            trig_second_q <= trig_second_d;
            wake_first_q <= wake_first_d;
            wake_second_q <= wake_second_d;
            hib_code_q <= hib_code_d;
            hib_flag_q <= hib_flag_d;
            irq_sts_q <= irq_sts_d;
            irq_mask_q <= irq_mask_d;
            st_q <= st_d;
            target_q <= target_d;
            pwr_q <= pwr_d;
            boot_q <= boot_d;
            prdata <= prdata_d;
            pready <= pready_d;
            pslverr <= pslverr_d;
            irq <= irq_d;
        end
    end

    assign power_ctl = pwr_q;
    assign boot_cause = boot_q;
endmodule : slpseq_top

// >>> src/slpseq_pkg.sv
package slpseq_pkg;

    // ********************************************************************
    // Register map (byte addresses on APB)
    // ********************************************************************
    localparam logic [7:0] ADDR_POWER_CONTROL_FIRST = 8'h00; // Sleep kind and trigger, first half
    localparam logic [7:0] ADDR_POWER_CONTROL_SECOND = 8'h04; // Sleep kind and trigger, second half
    localparam logic [7:0] ADDR_POWER_STATUS_FIRST = 8'h08; // Wake status, first half
    localparam logic [7:0] ADDR_POWER_STATUS_SECOND = 8'h0C; // Wake status, second half
    localparam logic [7:0] ADDR_FIRMWARE_COMMAND_PORT = 8'h10; // Firmware command port
    localparam logic [7:0] ADDR_FIRMWARE_CONFIG = 8'h14; // Hibernate code and supported flag
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18; // Sticky event bits, write one to clear
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C; // Event enable mask
    localparam logic [7:0] ADDR_SEQ_STATE = 8'h20; // Sequencer state and boot cause

    // ********************************************************************
    // Field positions
    // ********************************************************************
    localparam int SLEEP_KIND_LSB = 10; // Sleep kind field low bit
    localparam int SLEEP_KIND_W = 3; // Sleep kind field width
    localparam int SLEEP_TRIGGER_BIT = 13; // Trigger bit, write only
    localparam int WAKE_STATUS_BIT = 15; // Wake status bit in status registers
    localparam int HIB_SUPPORTED_BIT = 8; // Supported flag in firmware config
    localparam int IRQ_W = 4; // Number of event bits
    localparam int IRQ_SLEEP_ENTERED = 0; // Event: sleep entered
    localparam int IRQ_WAKE = 1; // Event: woke up
    localparam int IRQ_HIBERNATE_REQ = 2; // Event: hibernate request seen
    localparam int IRQ_POWER_BUTTON = 3; // Event: power button

    // ********************************************************************
    // Reset values and sleep kind codes
    // ********************************************************************
    localparam logic [7:0] HIB_CODE_RESET = 8'h00; // Firmware command code for hibernate
    localparam logic [2:0] KIND_S0 = 3'h0; // Working
    localparam logic [2:0] KIND_S1 = 3'h1; // Clocks stopped
    localparam logic [2:0] KIND_S2 = 3'h2; // CPU off
    localparam logic [2:0] KIND_S3 = 3'h3; // Memory retained
    localparam logic [2:0] KIND_S4 = 3'h4; // Hibernate
    localparam logic [2:0] KIND_S5 = 3'h5; // Soft off

    // ********************************************************************
    // Timing
    // ********************************************************************
    localparam int CLK_MHZ = 25; // System clock rate
    localparam int RESET_PULSE_NS = 1000; // Platform reset pulse on wake
    localparam int RESET_PULSE_CYC = (RESET_PULSE_NS * CLK_MHZ + 999) / 1000; // Rounded up
    localparam int SAVE_TIME_NS = 400; // Context save time before power off
    localparam int SAVE_CYC = (SAVE_TIME_NS * CLK_MHZ + 999) / 1000; // Rounded up

    // ********************************************************************
    // Types
    // ********************************************************************
    typedef enum logic [6:0] {
        ST_RUN = 7'h01,
        ST_ENTER = 7'h02,
        ST_SAVE = 7'h04,
        ST_CLK_STOP = 7'h08,
        ST_POWER_OFF = 7'h10,
        ST_WAKE_RESET = 7'h20,
        ST_RESTART_CLK = 7'h40
    } slpseq_state_t;

    typedef struct packed {
        logic clocks_run; // System clocks running
        logic cpu_power; // CPU and cache powered
        logic main_power; // Main system rail
        logic memory_self_refresh; // Memory in self refresh
        logic memory_isolate; // Memory isolated
        logic context_save; // Firmware context save in progress
        logic platform_reset_n; // Platform reset, active low
        logic cpu_reset_n; // CPU reset, active low
    } slpseq_power_t;

    typedef struct packed {
        logic cold_boot; // Boot through normal power on
        logic resume_vector; // Resume through waking vector
    } slpseq_boot_t;

endpackage : slpseq_pkg

// >>> src/slpseq_reset_sync.sv
`timescale 1ns/1ns
module slpseq_reset_sync (
    input wire logic clk,
    input wire logic rstn,
    output logic rst_sync_n
);
    import slpseq_pkg::*;

    // ********************************************************************
    // Two-stage release of the asynchronous reset
    // ********************************************************************
    logic stage_q; // First stage, read only by second
    logic stage_d;
    logic out_d;

    // Next values: shift a one in
    always_comb begin
        stage_d = 1'b1;
        out_d = stage_q;
    end

    // Registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage_q <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            stage_q <= stage_d;
            rst_sync_n <= out_d;
        end
    end
endmodule : slpseq_reset_sync

// >>> src/slpseq_timer.sv
`timescale 1ns/1ns
module slpseq_timer #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [WIDTH-1:0] count,
    output logic done
);
    import slpseq_pkg::*;

    // Width check
    if (WIDTH < 2) begin : g_chk
        $error("slpseq_timer: WIDTH too small");
    end

    // ********************************************************************
    // Down counter, done pulses one cycle when it reaches zero
    // ********************************************************************
    logic [WIDTH-1:0] cnt_q; // Remaining cycles
    logic [WIDTH-1:0] cnt_d;
    logic done_d;

    // Next values
    always_comb begin
        cnt_d = cnt_q;
        done_d = 1'b0;
        if (load) begin
            cnt_d = count;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
            done_d = (cnt_q == {{(WIDTH-1){1'b0}}, 1'b1});
        end
    end

    // Registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
            done <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            done <= done_d;
        end
    end
endmodule : slpseq_timer

// >>> verif/slpseq_checker.sv
`timescale 1ns/1ns
// ****************
// Port checker
// ****************
module slpseq_checker #(
    parameter int RESET_CYC = 2
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic wake_event,
    input wire slpseq_pkg::slpseq_power_t power_ctl,
    input wire slpseq_pkg::slpseq_boot_t boot_cause
);
    import slpseq_pkg::*;
    logic [7:0] low_q; // Powered cycles held in cpu reset
    logic [7:0] low_d; // Next count
    // Count only while powered, so an off state is not counted
    always_comb begin
        low_d = (!power_ctl.cpu_reset_n && power_ctl.main_power && power_ctl.clocks_run) ? low_q + 8'h01 : 8'h00;
    end
    // Register the count
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            low_q <= 8'h00;
        end else begin
            low_q <= low_d;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
    a_ready_in_access: assert property (pready |-> psel && penable) else $error("ready outside access");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_boot_one_cause: assert property (!(boot_cause.cold_boot && boot_cause.resume_vector))
        else $error("both boot causes set");
    a_clock_restart: assert property (!power_ctl.clocks_run && power_ctl.cpu_power && wake_event
        |-> ##[1:4] power_ctl.clocks_run) else $error("clocks not restarted");
    // Registered timer done and the state handover add two cycles to the count
    a_reset_pulse_len: assert property ($rose(power_ctl.cpu_reset_n) |-> low_q == RESET_CYC + 2)
        else $error("cpu reset pulse length wrong");
    a_wake_powered: assert property ($rose(power_ctl.platform_reset_n)
        |-> power_ctl.main_power && power_ctl.clocks_run) else $error("reset left while unpowered");
    a_save_then_off: assert property ($fell(power_ctl.context_save) |-> ##[0:3] !power_ctl.main_power)
        else $error("no power off after save");
    c_power_off: cover property ($fell(power_ctl.main_power));
    c_save: cover property ($rose(power_ctl.context_save));
    c_resume: cover property ($rose(boot_cause.resume_vector));
    c_slverr: cover property (pslverr);
endmodule : slpseq_checker

bind slpseq_top slpseq_checker #(.RESET_CYC(RESET_CYC)) u_slpseq_checker (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .wake_event(wake_event), .power_ctl(power_ctl),
    .boot_cause(boot_cause));

// >>> verif/sleep_state_sequencer_tb.sv
`timescale 1ns/1ns
module sleep_state_sequencer_tb;
    import slpseq_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic power_button = 1'b0, wake_event = 1'b0, pready, pslverr, irq;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, lfsr = 32'h7;
    slpseq_power_t power_ctl;
    slpseq_boot_t boot_cause;
    logic [31:0] rq[$], rm[$]; // Expected read data and masks
    logic [10:0] oq[$], om[$]; // Expected {irq, power, boot} and masks
    int err_total = 0, n_compared = 0;
    event oev;
    always #20 clk = ~clk;
    slpseq_top #(.RESET_CYC(4), .SAVE_CYCLES(2)) u_slpseq_top (.clk(clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .power_button(power_button), .wake_event(wake_event), .power_ctl(power_ctl),
        .boot_cause(boot_cause), .irq(irq));
    function logic [31:0] nxt(input logic [31:0] v);
        nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nxt
    task chk_rd(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_rd
    task chk_out(input logic [10:0] got, input logic [10:0] exp);
        chk_rd({21'h0, got}, {21'h0, exp});
    endtask : chk_out
    // Read data checked at the edge that ends the access
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite) begin
            chk_rd(prdata & rm[0], rq[0]);
            void'(rq.pop_front());
            void'(rm.pop_front());
        end
    end
    // Output notes checked when the driver posts them
    always @(oev) begin
        chk_out({irq, power_ctl, boot_cause} & om[0], oq[0]);
        void'(oq.pop_front());
        void'(om.pop_front());
    end
    // One APB transfer, held until ready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
        @(posedge clk);
        if (!w) begin
            rq.push_back(d & m);
            rm.push_back(m);
        end
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Wait, bounded, for an output pattern, then post it
    task pwr(input logic [10:0] m, input logic [10:0] e);
        int i;
        i = 0;
        while (i < 80 && (({irq, power_ctl, boot_cause} & m) !== e)) begin
            @(posedge clk);
            i++;
        end
        oq.push_back(e);
        om.push_back(m);
        ->oev;
    endtask : pwr
    // Clear wake status, then arm both controls
    task slp(input logic [2:0] k);
        logic [31:0] v;
        v = (32'(k) << SLEEP_KIND_LSB) | (32'h1 << SLEEP_TRIGGER_BIT);
        apb(1'b1, ADDR_POWER_STATUS_FIRST, 32'h8000, 32'h0);
        apb(1'b1, ADDR_POWER_STATUS_SECOND, 32'h8000, 32'h0);
        apb(1'b1, ADDR_POWER_CONTROL_FIRST, v, 32'h0);
        apb(1'b1, ADDR_POWER_CONTROL_SECOND, v, 32'h0);
    endtask : slp
    task wrap_up;
        if (err_total == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        apb(1'b0, ADDR_POWER_CONTROL_FIRST, 32'h0, 32'hFFFFFFFF);
        apb(1'b0, ADDR_FIRMWARE_CONFIG, 32'h0, 32'hFFFFFFFF);
        apb(1'b0, 8'h40, 32'h0, 32'hFFFFFFFF);
        pwr(11'h7FF, {1'b0, 8'hE3, 2'b10});
        for (int k = 0; k < 3; k++) begin
            lfsr = nxt(lfsr);
            apb(1'b1, ADDR_POWER_CONTROL_FIRST, lfsr & 32'hFFFFDFFF, 32'h0);
            apb(1'b1, ADDR_POWER_CONTROL_SECOND, lfsr & 32'hFFFFDFFF, 32'h0);
            apb(1'b0, ADDR_POWER_CONTROL_FIRST, lfsr, 32'h1C00);
        end
        pwr(11'h7FF, {1'b0, 8'hE3, 2'b10});
        apb(1'b1, ADDR_IRQ_MASK, 32'hF, 32'h0);
        slp(KIND_S1);
        pwr(11'h7FF, {1'b1, 8'h73, 2'b10});
        wake_event <= 1'b1;
        pwr(11'h3FF, {1'b0, 8'hE3, 2'b10});
        wake_event <= 1'b0;
        apb(1'b0, ADDR_POWER_STATUS_FIRST, 32'h8000, 32'h8000);
        apb(1'b0, ADDR_POWER_STATUS_SECOND, 32'h8000, 32'h8000);
        apb(1'b0, ADDR_POWER_CONTROL_FIRST, 32'h0400, 32'h1C00);
        apb(1'b1, ADDR_IRQ_MASK, 32'h0, 32'h0);
        pwr(11'h400, 11'h000);
        apb(1'b0, ADDR_IRQ_STATUS, 32'h3, 32'hF);
        apb(1'b1, ADDR_IRQ_STATUS, 32'hF, 32'h0);
        apb(1'b0, ADDR_IRQ_STATUS, 32'h0, 32'hF);
        slp(KIND_S5);
        pwr(11'h080, 11'h000);
        wake_event <= 1'b1;
        repeat (10) @(posedge clk);
        pwr(11'h080, 11'h000);
        wake_event <= 1'b0;
        power_button <= 1'b1;
        pwr(11'h3FF, {1'b0, 8'hE3, 2'b10});
        power_button <= 1'b0;
        apb(1'b0, ADDR_SEQ_STATE, 32'h1000, 32'h3000);
        apb(1'b1, ADDR_FIRMWARE_CONFIG, 32'h1A5, 32'h0);
        apb(1'b0, ADDR_FIRMWARE_CONFIG, 32'h1A5, 32'h1FF);
        apb(1'b1, ADDR_FIRMWARE_COMMAND_PORT, 32'hA4, 32'h0);
        repeat (10) @(posedge clk);
        pwr(11'h080, 11'h080);
        apb(1'b1, ADDR_FIRMWARE_COMMAND_PORT, 32'hA5, 32'h0);
        pwr(11'h010, 11'h010);
        pwr(11'h080, 11'h000);
        wake_event <= 1'b1;
        pwr(11'h3FF, {1'b0, 8'hE3, 2'b01});
        wake_event <= 1'b0;
        apb(1'b0, ADDR_SEQ_STATE, 32'h2000, 32'h3000);
        slp(KIND_S3);
        pwr(11'h080, 11'h000);
        wake_event <= 1'b1;
        pwr(11'h3FF, {1'b0, 8'hE3, 2'b01});
        wake_event <= 1'b0;
        wrap_up;
    end
    // Watchdog against a hang
    initial begin
        #400000;
        err_total++;
        wrap_up;
    end
endmodule : sleep_state_sequencer_tb
